// ---- verilog/asp_params.svh ----
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH
// Summary of operation
// [R1] each received byte moves from receive shifter into holding buffer
// [R2] seven-bit characters fill buffer bits 0..6, bit 7 reads zero
// [R3] on overrun the new character is discarded, buffer kept
// [R4] holding buffer is read-only; reset or power off force all ones
// [R5] writing the transmit shifter starts sending at once on the tx line
// [R6] transmit shifter write-only; reset, power off, tx disable set all ones
// [R7] host waits one base clock after tx enable before first write; core drops data writes until the second base tick after it
// [R8] host writes next character only after transmit done pulse
// [R9] control bit 7 gates the unit; zero resets status and data registers
// [R10] while power is off the rx line is seen as high
// [R11] bit 6 enables transmit, bit 5 receive; clearing resets that path
// [R12] bits 4:3 pick none, zero, odd or even parity
// [R13] zero parity mode never checks, never flags a parity error
// [R14] char length bit: 0 gives seven bits, 1 gives eight, both ways
// [R15] tx sends one or two stop bits; rx checks only the first
// [R16] host powers up before enabling and disables before powering down
// [R17] enabling receive while the line is low starts a reception
// [R18] enables sync to base clock; host waits two base clocks to re-enable
// [R19] host clears enables before changing parity, length or stop settings
// [R20] host always writes 1 to control bit 0
// [R21] error status read-only, upper bits zero, cleared by read or disable
// [R22] at completion flag parity mismatch, missing stop bit, unread overrun
// [R23] start-bit framed characters, transmit and receive run full duplex

// register word indices; byte address is four times the index
`define ASP_IDX_MODE 16'hff70
`define ASP_IDX_DATA 16'hff72
`define ASP_IDX_ERR  16'hff73
`define ASP_IDX_W    16

// reset values
`define ASP_MODE_RST 8'h01
`define ASP_DATA_RST 8'hff
`define ASP_ERR_RST  3'h0

// error status bit positions
`define ASP_E_PAR 2
`define ASP_E_FRM 1
`define ASP_E_OVR 0

// timing: clocks per base tick, base ticks per bit, enable sync depth
`define ASP_BASE_DIV 2
`define ASP_BIT_BASE 16
`define ASP_EN_SYNC  2
`endif

// ---- verilog/asp_pkg.sv ----
package asp_pkg;
    // mode register layout, msb first
    typedef struct packed {
        logic       power;
        logic       tx_en;
        logic       rx_en;
        logic [1:0] parity;
        logic       char8;
        logic       stop2;
        logic       fixed;
    } asp_mode_s;

    typedef enum logic [1:0] {
        ASP_PAR_NONE = 2'h0,
        ASP_PAR_ZERO = 2'h1,
        ASP_PAR_ODD  = 2'h2,
        ASP_PAR_EVEN = 2'h3
    } asp_par_e;

    // receiver states, gray along idle-start-data-parity-stop
    typedef enum logic [2:0] {
        ASP_RX_IDLE  = 3'h0,
        ASP_RX_START = 3'h1,
        ASP_RX_DATA  = 3'h3,
        ASP_RX_PAR   = 3'h2,
        ASP_RX_STOP  = 3'h6
    } asp_rx_e;
endpackage

// ---- verilog/asp_core.sv ----
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ns
`include "asp_params.svh"
module asp_core #(
    parameter int BASE_DIV = `ASP_BASE_DIV,
    parameter int BIT_BASE = `ASP_BIT_BASE
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [17:0] address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        serial_rx_line,
    output logic             serial_tx_line,
    output logic             transmit_done_interrupt,
    output logic             receive_done_pulse,
    output logic             receive_error_pulse
);
    import asp_pkg::*;

    localparam int CW = $clog2(BIT_BASE + 1);
    localparam int DW = $clog2(BASE_DIV + 1);
    localparam logic [CW-1:0] BIT_END = CW'(BIT_BASE - 1);
    localparam logic [CW-1:0] HALF = CW'(BIT_BASE / 2);

    asp_mode_s       mode;
    asp_mode_s       next_mode;
    logic      [7:0] rxb;
    logic      [7:0] next_rxb;
    logic            rxb_full;
    logic            next_rxb_full;
    logic            rxb_new;
    logic            next_rxb_new;
    logic      [2:0] err;
    logic      [2:0] next_err;
    logic      [2:0] err_snap;
    logic      [2:0] next_err_snap;
    logic      [7:0] txs;
    logic      [7:0] next_txs;
    logic     [31:0] next_readdata;
    logic            next_waitrequest;

    // bus decode; an access completes on the edge where waitrequest is low
    logic [`ASP_IDX_W-1:0] idx;
    logic                  done_rd;
    logic                  done_wr;
    assign idx = address[17:2];
    assign done_rd = read && !waitrequest;
    assign done_wr = write && !waitrequest;

    // base clock divider
    logic [DW-1:0] div_cnt;
    logic [DW-1:0] next_div_cnt;
    logic          base_tick;
    assign base_tick = (div_cnt == DW'(BASE_DIV - 1));

    // enables resampled on base ticks before the paths see them
    logic [`ASP_EN_SYNC-1:0] tx_en_s;
    logic [`ASP_EN_SYNC-1:0] rx_en_s;
    logic [`ASP_EN_SYNC-1:0] next_tx_en_s;
    logic [`ASP_EN_SYNC-1:0] next_rx_en_s;
    logic                    tx_on;
    logic                    rx_on;
    assign tx_on = tx_en_s[`ASP_EN_SYNC-1] && mode.tx_en;
    assign rx_on = rx_en_s[`ASP_EN_SYNC-1] && mode.rx_en;

    // powered-off unit sees an idle line
    logic rx_line;
    assign rx_line = mode.power ? serial_rx_line : 1'b1; // see [R10]

    // frame builder: start, data lsb first, parity, stop bits
    function automatic logic [11:0] tx_frame(input logic [7:0] d,
                                             input asp_mode_s m);
        logic [11:0] f;
        logic        p;
        int          n;
        f = '1;
        p = 1'b0;
        n = 1;
        f[0] = 1'b0; // see [R23]
        for (int i = 0; i < 8; i++) begin
            if (i < 7 || m.char8) begin // see [R14]
                f[n] = d[i];
                p = p ^ d[i];
                n = n + 1;
            end
        end
        case (m.parity) // see [R12]
            ASP_PAR_ZERO: f[n] = 1'b0;
            ASP_PAR_ODD:  f[n] = ~p;
            ASP_PAR_EVEN: f[n] = p;
            default:      f[n] = 1'b1;
        endcase
        return f;
    endfunction

    // bits in a frame incl. start and stop
    function automatic logic [3:0] tx_len(input asp_mode_s m);
        logic [3:0] l;
        l = m.char8 ? 4'h a : 4'h9;
        if (m.parity != ASP_PAR_NONE) begin
            l = l + 4'h1;
        end
        if (m.stop2) begin // see [R15]
            l = l + 4'h1;
        end
        return l;
    endfunction

    // register file and bus answer
    always_comb begin
        next_mode = mode;
        next_waitrequest = !((read || write) && waitrequest);
        next_readdata = readdata;
        next_err_snap = err_snap;
        if ((read || write) && waitrequest) begin
            next_readdata = '0;
            if (read) begin
                case (idx)
                    `ASP_IDX_MODE: next_readdata[7:0] = mode;
                    `ASP_IDX_ERR:  next_readdata[2:0] = err; // see [R21]
                    `ASP_IDX_DATA: next_readdata[7:0] = rxb;
                    default:       next_readdata = '0;
                endcase
            end
            next_err_snap = err;
        end
        if (done_wr && idx == `ASP_IDX_MODE) begin
            next_mode = writedata[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mode <= `ASP_MODE_RST;
            waitrequest <= 1'b1;
            readdata <= '0;
            err_snap <= '0;
        end else if (ce) begin
            mode <= next_mode;
            waitrequest <= next_waitrequest;
            readdata <= next_readdata;
            err_snap <= next_err_snap;
        end
    end

    // base tick and enable sampling; power off holds them cleared
    always_comb begin
        next_div_cnt = base_tick ? '0 : div_cnt + DW'(1);
        next_tx_en_s = tx_en_s;
        next_rx_en_s = rx_en_s;
        if (base_tick) begin // see [R18]
            next_tx_en_s = {tx_en_s[`ASP_EN_SYNC-2:0], mode.tx_en};
            next_rx_en_s = {rx_en_s[`ASP_EN_SYNC-2:0], mode.rx_en};
        end
        if (!mode.power) begin // see [R9]
            next_div_cnt = '0;
            next_tx_en_s = '0;
            next_rx_en_s = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            div_cnt <= '0;
            tx_en_s <= '0;
            rx_en_s <= '0;
        end else if (ce) begin
            div_cnt <= next_div_cnt;
            tx_en_s <= next_tx_en_s;
            rx_en_s <= next_rx_en_s;
        end
    end

    // transmitter
    logic          tx_busy;
    logic          next_tx_busy;
    logic [11:0]   tx_shift;
    logic [11:0]   next_tx_shift;
    logic [3:0]    tx_left;
    logic [3:0]    next_tx_left;
    logic [CW-1:0] tx_cnt;
    logic [CW-1:0] next_tx_cnt;
    logic          next_tx_line;
    logic          next_tx_done;
    logic          tx_load;
    // a write during a frame is dropped rather than corrupting it
    assign tx_load = done_wr && idx == `ASP_IDX_DATA && tx_on && !tx_busy;

    always_comb begin
        next_txs = txs;
        next_tx_busy = tx_busy;
        next_tx_shift = tx_shift;
        next_tx_left = tx_left;
        next_tx_cnt = tx_cnt;
        next_tx_done = 1'b0;
        if (tx_load) begin // see [R5]
            next_txs = writedata[7:0];
            next_tx_shift = tx_frame(writedata[7:0], mode);
            next_tx_left = tx_len(mode);
            next_tx_cnt = '0;
            next_tx_busy = 1'b1;
        end else if (tx_busy && base_tick) begin
            next_tx_cnt = tx_cnt + CW'(1);
            if (tx_cnt == BIT_END) begin
                next_tx_cnt = '0;
                next_tx_shift = {1'b1, tx_shift[11:1]};
                next_tx_left = tx_left - 4'h1;
                if (tx_left == 4'h1) begin
                    next_tx_busy = 1'b0;
                    next_tx_done = 1'b1;
                end
            end
        end
        if (!tx_on || !mode.power) begin // see [R11]
            next_tx_busy = 1'b0;
            next_tx_done = 1'b0;
        end
        if (!mode.tx_en || !mode.power) begin // see [R6]
            next_txs = `ASP_DATA_RST;
        end
        next_tx_line = next_tx_busy ? next_tx_shift[0] : 1'b1;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            txs <= `ASP_DATA_RST;
            tx_busy <= 1'b0;
            tx_shift <= '1;
            tx_left <= '0;
            tx_cnt <= '0;
            serial_tx_line <= 1'b1;
            transmit_done_interrupt <= 1'b0;
        end else if (ce) begin
            txs <= next_txs;
            tx_busy <= next_tx_busy;
            tx_shift <= next_tx_shift;
            tx_left <= next_tx_left;
            tx_cnt <= next_tx_cnt;
            serial_tx_line <= next_tx_line;
            transmit_done_interrupt <= next_tx_done;
        end
    end

    // receiver
    asp_rx_e       rx_st;
    asp_rx_e       next_rx_st;
    logic [CW-1:0] rx_cnt;
    logic [CW-1:0] next_rx_cnt;
    logic [3:0]    rx_bits;
    logic [3:0]    next_rx_bits;
    logic [7:0]    rx_data;
    logic [7:0]    next_rx_data;
    logic          rx_par;
    logic          next_rx_par;
    logic          rx_end;
    logic          rx_store;
    logic          next_rx_done;
    logic          next_rx_err;
    logic [2:0]    rx_set;
    logic [7:0]    rx_char;
    logic          rx_mid;
    assign rx_mid = base_tick && rx_cnt == BIT_END;
    // seven-bit data ends up in the top bits of the shifter
    assign rx_char = mode.char8 ? rx_data : {1'b0, rx_data[7:1]}; // see [R2]

    always_comb begin
        next_rx_st = rx_st;
        next_rx_cnt = rx_cnt;
        next_rx_bits = rx_bits;
        next_rx_data = rx_data;
        next_rx_par = rx_par;
        rx_end = 1'b0;
        if (base_tick) begin
            next_rx_cnt = rx_cnt + CW'(1);
        end
        case (rx_st)
            ASP_RX_IDLE: begin
                next_rx_cnt = '0;
                if (base_tick && !rx_line) begin // see [R17]
                    next_rx_st = ASP_RX_START;
                    next_rx_cnt = CW'(1);
                end
            end
            ASP_RX_START: begin
                if (base_tick && rx_cnt == HALF) begin
                    next_rx_cnt = '0;
                    next_rx_bits = '0;
                    next_rx_st = rx_line ? ASP_RX_IDLE : ASP_RX_DATA;
                end
            end
            ASP_RX_DATA: begin
                if (rx_mid) begin
                    next_rx_cnt = '0;
                    next_rx_data = {rx_line, rx_data[7:1]};
                    next_rx_bits = rx_bits + 4'h1;
                    if (rx_bits == (mode.char8 ? 4'h7 : 4'h6)) begin
                        next_rx_st = (mode.parity == ASP_PAR_NONE) ?
                                     ASP_RX_STOP : ASP_RX_PAR;
                    end
                end
            end
            ASP_RX_PAR: begin
                if (rx_mid) begin
                    next_rx_cnt = '0;
                    next_rx_par = rx_line;
                    next_rx_st = ASP_RX_STOP;
                end
            end
            ASP_RX_STOP: begin
                if (rx_mid) begin // see [R15]
                    rx_end = 1'b1;
                    next_rx_st = ASP_RX_IDLE;
                end
            end
            default: next_rx_st = ASP_RX_IDLE;
        endcase
        if (!rx_on || !mode.power) begin // see [R11]
            next_rx_st = ASP_RX_IDLE;
            rx_end = 1'b0;
        end
    end

    // completion flags and holding buffer update
    always_comb begin
        rx_set = '0;
        rx_set[`ASP_E_FRM] = rx_end && !rx_line;
        // parity checked only in odd or even mode
        rx_set[`ASP_E_PAR] = rx_end && mode.parity[1] && // see [R13]
                             ((^rx_char ^ rx_par) == mode.parity[0]);
        rx_set[`ASP_E_OVR] = rx_end && rxb_full; // see [R22]
        rx_store = rx_end && !rxb_full; // see [R3]
        next_rx_done = rx_store;
        next_rx_err = |rx_set;
        next_rxb = rxb;
        next_rxb_full = rxb_full;
        next_rxb_new = rxb_new;
        if ((read || write) && waitrequest) begin
            next_rxb_new = 1'b0;
        end
        if (done_rd && idx == `ASP_IDX_DATA && !rxb_new) begin
            next_rxb_full = 1'b0;
        end
        // snapshot clear; a flag set in the same cycle survives
        next_err = err;
        if (done_rd && idx == `ASP_IDX_ERR) begin
            next_err = err & ~err_snap; // see [R21]
        end
        next_err = next_err | rx_set; // see [R22]
        if (rx_store) begin // see [R1]
            next_rxb = rx_char;
            next_rxb_full = 1'b1;
            next_rxb_new = 1'b1;
        end
        if (!mode.rx_en) begin
            next_err = `ASP_ERR_RST;
            next_rxb_full = 1'b0;
        end
        if (!mode.power) begin // see [R4]
            next_rxb = `ASP_DATA_RST;
            next_err = `ASP_ERR_RST;
            next_rxb_full = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rx_st <= ASP_RX_IDLE;
            rx_cnt <= '0;
            rx_bits <= '0;
            rx_data <= '0;
            rx_par <= 1'b0;
            rxb <= `ASP_DATA_RST;
            rxb_full <= 1'b0;
            rxb_new <= 1'b0;
            err <= `ASP_ERR_RST;
            receive_done_pulse <= 1'b0;
            receive_error_pulse <= 1'b0;
        end else if (ce) begin
            rx_st <= next_rx_st;
            rx_cnt <= next_rx_cnt;
            rx_bits <= next_rx_bits;
            rx_data <= next_rx_data;
            rx_par <= next_rx_par;
            rxb <= next_rxb;
            rxb_full <= next_rxb_full;
            rxb_new <= next_rxb_new;
            err <= next_err;
            receive_done_pulse <= next_rx_done;
            receive_error_pulse <= next_rx_err;
        end
    end

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst || !ce);

    wait_answer_a: assert property ( // see [R21]
        (read || write) && waitrequest |=> !waitrequest)
        else $error("no answer one cycle after request");
    wait_pulse_a: assert property (
        !waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    rxb_power_a: assert property ( // see [R4]
        !mode.power |=> rxb == `ASP_DATA_RST)
        else $error("holding buffer not all ones with power off");
    txs_off_a: assert property ( // see [R6]
        !mode.tx_en |=> txs == `ASP_DATA_RST)
        else $error("transmit shifter not all ones when disabled");
    start_bit_a: assert property ( // see [R5]
        tx_load |=> !serial_tx_line && tx_busy)
        else $error("start bit not driven after write");
    err_rx_off_a: assert property ( // see [R21]
        !mode.rx_en |=> err == `ASP_ERR_RST)
        else $error("error status not cleared when rx disabled");
    zero_par_a: assert property ( // see [R13]
        mode.parity == ASP_PAR_ZERO |=> !$rose(err[`ASP_E_PAR]))
        else $error("parity error raised in zero parity mode");
    ovr_keep_a: assert property ( // see [R3]
        rx_end && rxb_full && mode.power |=> $stable(rxb) && err[`ASP_E_OVR])
        else $error("overrun character overwrote buffer");
    seven_msb_a: assert property ( // see [R2]
        rx_store && !mode.char8 |=> rxb[7] == 1'b0 && receive_done_pulse)
        else $error("seven bit character has msb set");
    rx_idle_a: assert property ( // see [R10]
        !mode.power |=> rx_st == ASP_RX_IDLE [*2])
        else $error("receiver active with power off");

    tx_frame_c: cover property (tx_load ##[1:400] transmit_done_interrupt);
    rx_frame_c: cover property (rx_store ##1 receive_done_pulse);
    overrun_c: cover property (rx_end && rxb_full);
    frame_err_c: cover property (rx_set[`ASP_E_FRM]);
endmodule

// ---- verification/asp_remote.sv ----
`timescale 1ns/1ns
// far-end serial peer; idle line sits high like a pulled-up wire
module asp_remote #(
    parameter int BITC = 8
) (
    input  wire logic       clock,
    input  wire logic       line_in,
    input  wire logic       char8,
    input  wire logic [1:0] par,
    output logic            line_out
);
    import asp_pkg::*;
    logic [7:0] got_data;
    logic       got_par;
    logic       got_stop;
    initial line_out = 1'b1;

    // one bit time on the line, entered just after a clock edge
    task automatic put_bit(input logic b);
        line_out <= b;
        repeat (BITC) @(posedge clock);
    endtask

    // whole frame, lsb first; bad_par and bad_stop break it on purpose
    task automatic send(input logic [7:0] d, input logic bad_par,
                        input logic bad_stop);
        logic [7:0] dm;
        logic       p;
        dm = char8 ? d : {1'b0, d[6:0]};
        p = (par == ASP_PAR_ODD) ? ~^dm : (par == ASP_PAR_EVEN) ? ^dm : 1'b0;
        put_bit(1'b0);
        for (int i = 0; i < (char8 ? 8 : 7); i++) begin
            put_bit(dm[i]);
        end
        if (par != ASP_PAR_NONE) begin
            put_bit(p ^ bad_par);
        end
        put_bit(~bad_stop);
        // a good stop bit already idles high; one drive per step back to back
        if (bad_stop) begin
            line_out <= 1'b1;
        end
    endtask

    // decode the device's tx line at mid-bit
    always begin
        @(negedge line_in);
        repeat (BITC / 2) @(posedge clock);
        got_data = 8'h00;
        for (int i = 0; i < (char8 ? 8 : 7); i++) begin
            repeat (BITC) @(posedge clock);
            got_data[i] = line_in;
        end
        if (par != ASP_PAR_NONE) begin
            repeat (BITC) @(posedge clock);
            got_par = line_in;
        end
        repeat (BITC) @(posedge clock);
        got_stop = line_in;
    end
endmodule

// ---- verification/test_async_serial_port_core.sv ----
`timescale 1ns/1ns
`include "asp_params.svh"
module test_async_serial_port_core;
    import asp_pkg::*;
    // short bit time keeps the run brief: 2 clocks a tick, 4 ticks a bit
    localparam int BDIV = 2;
    localparam int BBASE = 4;
    localparam int BITC = BDIV * BBASE;
    typedef struct packed {
        asp_par_e   par;
        logic       char8;
        logic       stop2;
        logic [7:0] txd;
        logic [7:0] rxd;
        logic       bad_par;
        logic       bad_stop;
        logic [7:0] exp_rx;
        logic [7:0] exp_err;
    } asp_row_s;
    // five rows: every parity mode with none twice, both lengths, both stop counts
    asp_row_s    rows [5] = '{
        '{ASP_PAR_NONE, 1'b1, 1'b0, 8'ha5, 8'h3c, 1'b0, 1'b0, 8'h3c, 8'h00},
        '{ASP_PAR_ZERO, 1'b0, 1'b1, 8'h5a, 8'hd3, 1'b1, 1'b0, 8'h53, 8'h00},
        '{ASP_PAR_ODD, 1'b1, 1'b0, 8'h0f, 8'h81, 1'b0, 1'b0, 8'h81, 8'h00},
        '{ASP_PAR_EVEN, 1'b1, 1'b1, 8'hf0, 8'h81, 1'b1, 1'b0, 8'h81, 8'h04},
        '{ASP_PAR_NONE, 1'b1, 1'b0, 8'h00, 8'h7e, 1'b0, 1'b1, 8'h7e, 8'h02}
    };
    logic        clock;
    logic        rst;
    logic        ce;
    logic [17:0] address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        rx_line;
    logic        tx_line;
    logic        tx_done;
    logic        rx_done;
    logic        rx_err;
    asp_mode_s   mode_q = 8'h01;
    asp_mode_s   m;
    int          n_errors = 0, samples_checked = 0, cycle = 0;
    int          tx_done_at = 0, n_rx_done = 0, n_err_pulse = 0;
    int          n_tx_low = 0, t0, rx0, e0, low0, bits;

    asp_core #(.BASE_DIV(BDIV), .BIT_BASE(BBASE)) asp_core_i (
        .clock(clock), .rst(rst), .ce(ce), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .serial_rx_line(rx_line), .serial_tx_line(tx_line),
        .transmit_done_interrupt(tx_done), .receive_done_pulse(rx_done),
        .receive_error_pulse(rx_err)
    );
    asp_remote #(.BITC(BITC)) asp_remote_i (
        .clock(clock), .line_in(tx_line), .char8(mode_q.char8),
        .par(mode_q.parity), .line_out(rx_line)
    );

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // event counters; the cycle ceiling cuts a hang short
    always @(posedge clock) begin
        cycle <= cycle + 1;
        if (tx_done === 1'b1) tx_done_at <= cycle;
        if (rx_done === 1'b1) n_rx_done <= n_rx_done + 1;
        if (rx_err === 1'b1) n_err_pulse <= n_err_pulse + 1;
        if (tx_line === 1'b0) n_tx_low <= n_tx_low + 1;
        if (cycle == 20000) begin
            n_errors = n_errors + 1;
            finish_test();
        end
    end

    task automatic check(input string name, input logic [31:0] got,
                         input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // one avalon transfer; request held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [15:0] idx,
                       input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock);
        address <= {idx, 2'b00};
        writedata <= {24'h00_0000, d};
        read <= ~wr;
        write <= wr;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 100);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        check("waitrequest", waitrequest, 32'h0000_0000);
    endtask

    task automatic wr_reg(input logic [15:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask

    task automatic rd_chk(input string name, input logic [15:0] idx,
                          input logic [7:0] exp);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, q);
        check(name, q, {24'h00_0000, exp});
    endtask

    // mode write, then more than two base ticks before anything else
    task automatic set_mode(input asp_mode_s v);
        wr_reg(`ASP_IDX_MODE, v);
        mode_q = v;
        repeat (8) @(posedge clock);
    endtask

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 18'h0_0000;
        writedata = 32'h0000_0000;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        rd_chk("mode reset", `ASP_IDX_MODE, 8'h01);
        rd_chk("err reset", `ASP_IDX_ERR, 8'h00);
        rd_chk("data reset", `ASP_IDX_DATA, 8'hff);
        foreach (rows[i]) begin
            m = mode_q;
            m.power = 1'b1;
            m.tx_en = 1'b0;
            m.rx_en = 1'b0;
            set_mode(m);
            m = {3'b100, rows[i].par, rows[i].char8, rows[i].stop2, 1'b1};
            set_mode(m);
            m.tx_en = 1'b1;
            m.rx_en = 1'b1;
            set_mode(m);
            rd_chk("mode rw", `ASP_IDX_MODE, m);
            rx0 = n_rx_done;
            e0 = n_err_pulse;
            bits = (m.char8 ? 10 : 9) + (m.parity != 0) + m.stop2;
            // transmit and receive at once
            fork
                begin
                    wr_reg(`ASP_IDX_DATA, rows[i].txd);
                    t0 = cycle;
                    for (int k = 0; k < 300 && tx_done_at <= t0; k++) begin
                        @(posedge clock);
                    end
                end
                asp_remote_i.send(rows[i].rxd, rows[i].bad_par,
                                  rows[i].bad_stop);
            join
            // done seen bits * BITC cycles after the write, one more by tick phase
            bits = tx_done_at - t0 - bits * BITC;
            check("frame time", bits inside {0, 1}, 1);
            check("peer data", asp_remote_i.got_data,
                  rows[i].txd & (m.char8 ? 8'hff : 8'h7f));
            check("peer stop", asp_remote_i.got_stop, 1);
            if (m.parity != ASP_PAR_NONE) begin
                check("peer parity", asp_remote_i.got_par,
                      m.parity == ASP_PAR_ODD ? ~^asp_remote_i.got_data :
                      m.parity == ASP_PAR_EVEN ? ^asp_remote_i.got_data :
                      1'b0);
            end
            check("rx stored", n_rx_done - rx0, 1);
            check("err pulse", n_err_pulse - e0,
                  rows[i].exp_err != 8'h00);
            rd_chk("err", `ASP_IDX_ERR, rows[i].exp_err);
            rd_chk("data", `ASP_IDX_DATA, rows[i].exp_rx);
        end
        // two frames unread: second one dropped, overrun flagged
        asp_remote_i.send(8'h11, 1'b0, 1'b0);
        asp_remote_i.send(8'h22, 1'b0, 1'b0);
        rd_chk("overrun", `ASP_IDX_ERR, 8'h01);
        rd_chk("kept", `ASP_IDX_DATA, 8'h11);
        rd_chk("read clear", `ASP_IDX_ERR, 8'h00);
        wr_reg(`ASP_IDX_ERR, 8'hff);
        rd_chk("err ro", `ASP_IDX_ERR, 8'h00);
        rd_chk("unmapped", 16'hff71, 8'h00);
        // transmit off: a data write must not reach the line
        set_mode(8'ha5);
        low0 = n_tx_low;
        wr_reg(`ASP_IDX_DATA, 8'h00);
        repeat (3 * BITC) @(posedge clock);
        check("tx silent", n_tx_low - low0, 0);
        asp_remote_i.send(8'h5a, 1'b0, 1'b1);
        set_mode(8'h85);
        rd_chk("rx off err", `ASP_IDX_ERR, 8'h00);
        rd_chk("rx off data", `ASP_IDX_DATA, 8'h5a);
        set_mode(8'h05);
        rd_chk("power off", `ASP_IDX_DATA, 8'hff);
        // enabling receive onto a low line starts a frame at once
        set_mode(8'h85);
        rx0 = n_rx_done;
        asp_remote_i.put_bit(1'b0);
        set_mode(8'ha5);
        // line stays low past the sync delay and the half-bit start check
        repeat (4) @(posedge clock);
        asp_remote_i.put_bit(1'b1);
        repeat (12 * BITC) @(posedge clock);
        check("low enable", n_rx_done - rx0, 1);
        finish_test();
    end
endmodule
